// File: hdl/nor_sync_strobe.sv
// Strobe timing generator for synchronous burst NOR accesses.
// Assumes requests and configuration come from logic on mclk and that the
// timing fields stay steady while busy is high.
`timescale 1ns/1ps
module nor_sync_strobe #(
    parameter int NCS = nor_sync_pkg::NUM_CS
) (
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              rst_n,
    // Access request
    input  wire logic                              req_start,
    input  wire logic                              req_write,
    input  wire logic [nor_sync_pkg::BURST_W-1:0]  req_extra_beats,
    input  wire logic [nor_sync_pkg::CS_W-1:0]     req_select,
    input  wire logic [nor_sync_pkg::DATA_W-1:0]   wr_data,
    // Timing configuration
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   select_on_tick,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   select_read_off_tick,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   select_write_off_tick,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   latch_on_tick,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   latch_read_off_tick,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   latch_write_off_tick,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   read_strobe_on_tick,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   read_strobe_off_tick,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   write_strobe_on_tick,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   write_strobe_off_tick,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   read_cycle_ticks,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   write_cycle_ticks,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   access_ticks,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   burst_access_ticks,
    input  wire logic [nor_sync_pkg::TICK_W-1:0]   clock_start_tick,
    input  wire logic [nor_sync_pkg::SCALE_W-1:0]  tick_scale,
    input  wire logic                              select_half_delay,
    input  wire logic                              latch_half_delay,
    input  wire logic                              read_strobe_half_delay,
    input  wire logic                              write_strobe_half_delay,
    input  wire logic [NCS*nor_sync_pkg::DIV_W-1:0] out_clock_divider,
    // Status
    output logic                                   busy,
    output logic                                   done,
    output logic                                   wr_data_take,
    output logic                                   rd_sample,
    // Memory pins
    output logic                                   mem_clk,
    output logic [NCS-1:0]                         mem_cs_n,
    output logic                                   mem_adv_n,
    output logic                                   mem_oe_n,
    output logic                                   mem_we_n,
    output logic [nor_sync_pkg::BEN_W-1:0]         mem_ben_n,
    output logic [nor_sync_pkg::DATA_W-1:0]        mem_wdata
);
    import nor_sync_pkg::*;

    // Sequencer state.
    seq_state_e         state_reg, state_next;
    logic [CYC_W-1:0]   cyc_reg, cyc_next;
    logic               wr_reg, wr_next;
    logic [BURST_W-1:0] beats_reg, beats_next;
    logic [CS_W-1:0]    sel_reg, sel_next;
    logic [DIV_W-1:0]   div_reg, div_next;
    logic               run_next;

    // Event cycles derived from the configuration.
    logic [CYC_W-1:0] burst_cyc, end_cyc, acc_cyc;
    logic [CYC_W-1:0] cs_on, cs_off, adv_on, adv_off;
    logic [CYC_W-1:0] oe_on, oe_off, we_on, we_off;
    logic [CYC_W-1:0] clk_on;

    // Pin state, registered on the rising edge.
    logic [NCS-1:0]    cs_reg, cs_next;
    logic              adv_reg, adv_next;
    logic              oe_reg, oe_next;
    logic              we_reg, we_next;
    logic [BEN_W-1:0]  ben_reg, ben_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic              take_reg, take_next;
    logic              done_reg, done_next;
    logic              samp_reg, samp_next;
    logic [CYC_W-1:0]  samp_at_reg, samp_at_next;
    logic [BURST_W:0]  words_reg, words_next;
    logic [BURST_W:0]  samps_reg, samps_next;

    // Half-cycle delayed copies, registered on the falling edge.
    logic [NCS-1:0] cs_neg_reg;
    logic           adv_neg_reg, oe_neg_reg, we_neg_reg;

    logic clk_rise;

    // Scaled tick plus the residue that lands it on the output clock.
    function automatic logic [CYC_W-1:0] place(
        input logic [TICK_W-1:0] t);
        return scaled(CYC_W'(t), tick_scale)
               + residue(t, clock_start_tick, div_reg);
    endfunction : place

    // Edge placement per strobe; residues land edges on the output clock.
    always_comb begin
        burst_cyc = scaled(CYC_W'(burst_access_ticks), tick_scale)
                    * CYC_W'(beats_reg);
        clk_on    = CYC_W'(clock_start_tick);
        acc_cyc   = scaled(CYC_W'(access_ticks), tick_scale);
        // R8 R9 R10 R11 select assert offset
        cs_on  = place(select_on_tick);
        // R1 R2 R3 R7 select release keeps the exact width
        cs_off = scaled(CYC_W'(wr_reg ? select_write_off_tick
                                      : select_read_off_tick), tick_scale)
                 + burst_cyc
                 + residue(select_on_tick, clock_start_tick, div_reg);
        // R12 latch assert alignment
        adv_on = place(latch_on_tick);
        // R13 R14 latch release alignment
        adv_off = place(wr_reg ? latch_write_off_tick
                               : latch_read_off_tick);
        // R15 R16 read strobe alignment
        oe_on  = place(read_strobe_on_tick);
        oe_off = place(read_strobe_off_tick) + burst_cyc;
        // R17 R18 write strobe alignment
        we_on  = place(write_strobe_on_tick);
        we_off = place(write_strobe_off_tick) + burst_cyc;
        // R5 R6 byte enable window sets the access length
        end_cyc = scaled(CYC_W'(wr_reg ? write_cycle_ticks
                                       : read_cycle_ticks), tick_scale)
                  + burst_cyc;
    end

    // Sequencer: idle, running on the cycle counter, one-cycle done.
    always_comb begin
        state_next = state_reg;
        cyc_next   = cyc_reg;
        wr_next    = wr_reg;
        beats_next = beats_reg;
        sel_next   = sel_reg;
        div_next   = div_reg;
        case (state_reg)
            ST_IDLE: begin
                if (req_start) begin
                    state_next = ST_RUN;
                    cyc_next   = '0;
                    wr_next    = req_write;
                    beats_next = req_extra_beats;
                    sel_next   = req_select;
                    // R20 divider picked by chip select
                    div_next   = out_clock_divider[req_select*DIV_W +: DIV_W];
                end
            end
            ST_RUN: begin
                cyc_next = cyc_reg + CYC_ONE;
                if (cyc_next >= end_cyc) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // R4 clock starts unscaled after address valid
        run_next = (state_next == ST_RUN) && (cyc_next >= clk_on);
    end

    // Sequencer registers.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cyc_reg   <= '0;
            wr_reg    <= 1'b0;
            beats_reg <= '0;
            sel_reg   <= '0;
            div_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cyc_reg   <= cyc_next;
            wr_reg    <= wr_next;
            beats_reg <= beats_next;
            sel_reg   <= sel_next;
            div_reg   <= div_next;
        end
    end

    // Strobe levels for the coming cycle; active low at the pins.
    // The windows use the previous event set on the first cycle, which
    // is harmless because every window opens no earlier than cycle zero.
    always_comb begin
        logic act;
        act      = (state_next == ST_RUN);
        cs_next  = {NCS{STROBE_IDLE}};
        // R1 R2 R3 select low between its edges
        if (act && cyc_next >= cs_on && cyc_next < cs_off) begin
            cs_next[sel_next] = 1'b0;
        end
        adv_next = !(act && cyc_next >= adv_on && cyc_next < adv_off);
        oe_next  = !(act && !wr_next && cyc_next >= oe_on
                     && cyc_next < oe_off);
        we_next  = !(act && wr_next && cyc_next >= we_on
                     && cyc_next < we_off);
        // R5 byte enables low from address valid to cycle end
        ben_next = (act && cyc_next < end_cyc) ? '0 : {BEN_W{STROBE_IDLE}};
        done_next = (state_next == ST_DONE);
    end

    // Write data and read sample points.
    always_comb begin
        wdata_next   = wdata_reg;
        take_next    = 1'b0;
        words_next   = words_reg;
        samp_next    = 1'b0;
        samp_at_next = samp_at_reg;
        samps_next   = samps_reg;
        if (state_reg == ST_IDLE) begin
            words_next   = '0;
            samps_next   = '0;
            samp_at_next = '0;
        end else if (state_reg == ST_RUN) begin
            // R19 data moves one cycle after the clock rise
            if (wr_reg && clk_rise && words_reg <= (BURST_W+1)'(beats_reg))
            begin
                wdata_next = wr_data;
                take_next  = 1'b1;
                words_next = words_reg + 1'b1;
            end
            // R6 R7 reference edge at the access point of each beat
            if (!wr_reg && samps_reg <= (BURST_W+1)'(beats_reg)
                && cyc_reg == acc_cyc + samp_at_reg) begin
                samp_next    = 1'b1;
                samps_next   = samps_reg + 1'b1;
                samp_at_next = samp_at_reg
                               + scaled(CYC_W'(burst_access_ticks),
                                        tick_scale);
            end
        end
    end

    // Pin, data and status registers on the rising edge.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cs_reg      <= {NCS{STROBE_IDLE}};
            adv_reg     <= STROBE_IDLE;
            oe_reg      <= STROBE_IDLE;
            we_reg      <= STROBE_IDLE;
            ben_reg     <= {BEN_W{STROBE_IDLE}};
            done_reg    <= 1'b0;
            wdata_reg   <= DATA_RST;
            take_reg    <= 1'b0;
            words_reg   <= '0;
            samp_reg    <= 1'b0;
            samp_at_reg <= '0;
            samps_reg   <= '0;
        end else begin
            cs_reg      <= cs_next;
            adv_reg     <= adv_next;
            oe_reg      <= oe_next;
            we_reg      <= we_next;
            ben_reg     <= ben_next;
            done_reg    <= done_next;
            wdata_reg   <= wdata_next;
            take_reg    <= take_next;
            words_reg   <= words_next;
            samp_reg    <= samp_next;
            samp_at_reg <= samp_at_next;
            samps_reg   <= samps_next;
        end
    end

    // R8 half-cycle copies taken on the falling edge
    always_ff @(negedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cs_neg_reg  <= {NCS{STROBE_IDLE}};
            adv_neg_reg <= STROBE_IDLE;
            oe_neg_reg  <= STROBE_IDLE;
            we_neg_reg  <= STROBE_IDLE;
        end else begin
            cs_neg_reg  <= cs_reg;
            adv_neg_reg <= adv_reg;
            oe_neg_reg  <= oe_reg;
            we_neg_reg  <= we_reg;
        end
    end

    // Output clock generator; runs only inside an access.
    out_clock_gen u_clk (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .run     (run_next),
        .div     (div_next),
        .mem_clk (mem_clk),
        .rise    (clk_rise)
    );

    // The half-cycle selects are static settings, so the select between a
    // rising and a falling flop cannot glitch during an access.
    assign mem_cs_n     = select_half_delay ? cs_neg_reg : cs_reg;
    assign mem_adv_n    = latch_half_delay ? adv_neg_reg : adv_reg;
    assign mem_oe_n     = read_strobe_half_delay ? oe_neg_reg : oe_reg;
    assign mem_we_n     = write_strobe_half_delay ? we_neg_reg : we_reg;
    assign mem_ben_n    = ben_reg;
    assign mem_wdata    = wdata_reg;
    assign wr_data_take = take_reg;
    assign rd_sample    = samp_reg;
    assign done         = done_reg;
    assign busy         = (state_reg == ST_RUN);

endmodule : nor_sync_strobe

// File: inc/nor_sync_pkg.sv
// Constants, types and helper arithmetic for the synchronous burst NOR
// strobe timing generator. Assumes one functional clock for all logic.
// Contract
// R1 - Single read: select low (select_read_off minus select_on) times scale.
// R2 - Burst read adds (n-1) burst_access_ticks to select low time, scaled.
// R3 - Burst write: select low (write_off minus on plus burst part) scaled.
// R4 - Output clock starts clock_start_tick plain cycles after address valid.
// R5 - Byte enables low for cycle ticks plus burst part, scaled.
// R6 - Latch and byte enables released cycle minus access after reference.
// R7 - Select and read strobe released off minus access after reference.
// R8 - Divider 0: select assert delayed only by optional half cycle.
// R9 - Divider 1: one extra cycle unless parities of ticks match.
// R10 - Divider 2: select assert offset by difference modulo 3.
// R11 - Divider 3: select assert offset by difference modulo 4.
// R12 - Latch assert aligned the same way using latch_on_tick.
// R13 - Read latch release aligned using latch_read_off_tick.
// R14 - Write latch release aligned using latch_write_off_tick.
// R15 - Read strobe assert aligned using read_strobe_on_tick.
// R16 - Read strobe release aligned using read_strobe_off_tick.
// R17 - Write strobe assert aligned using write_strobe_on_tick.
// R18 - Write strobe release aligned using write_strobe_off_tick.
// R19 - Write data changes one functional clock after output clock rise.
// R20 - Output clock divider is chosen per chip select.
// R21 - Output clock is functional clock divided by divider plus one.
package nor_sync_pkg;

    localparam int TICK_W  = 5;
    localparam int SCALE_W = 2;
    localparam int DIV_W   = 2;
    localparam int BURST_W = 4;
    localparam int CS_W    = 3;
    localparam int NUM_CS  = 8;
    localparam int BEN_W   = 2;
    localparam int DATA_W  = 16;
    localparam int CYC_W   = 12;

    // Multiple of 2, 3 and 4 above the largest tick, keeps residues positive.
    localparam logic [7:0]        MOD_BIAS    = 8'h60;
    localparam logic [7:0]        MOD3        = 8'h03;
    localparam logic              STROBE_IDLE = 1'b1;
    localparam logic [DATA_W-1:0] DATA_RST    = 16'h0000;
    localparam logic [CYC_W-1:0]  CYC_ONE     = 12'h001;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_DONE = 3'b100
    } seq_state_e;

    // Tick count times (tick_scale + 1), in functional clock cycles.
    function automatic logic [CYC_W-1:0] scaled(
        input logic [CYC_W-1:0]   t,
        input logic [SCALE_W-1:0] s);
        logic [CYC_W-1:0] f;
        f = CYC_W'(s) + CYC_W'(1);
        scaled = CYC_W'(t * f);
    endfunction : scaled

    // Whole cycles needed to land an edge on the divided output clock.
    function automatic logic [CYC_W-1:0] residue(
        input logic [TICK_W-1:0] t,
        input logic [TICK_W-1:0] c,
        input logic [DIV_W-1:0]  div);
        logic [7:0] d;
        d = 8'(t) + MOD_BIAS - 8'(c);
        case (div)
            2'h0:    residue = '0;
            2'h1:    residue = CYC_W'(d[0]);
            2'h2:    residue = CYC_W'(d % MOD3);
            default: residue = CYC_W'(d[1:0]);
        endcase
    endfunction : residue

endpackage : nor_sync_pkg

// File: hdl/out_clock_gen.sv
// Divided output memory clock and its rising-edge marker.
// Assumes run is computed on the same functional clock.
`timescale 1ns/1ps
module out_clock_gen (
    // Clock and reset
    input  wire logic                            mclk,
    input  wire logic                            rst_n,
    // Control
    input  wire logic                            run,
    input  wire logic [nor_sync_pkg::DIV_W-1:0]  div,
    // Clock out
    output logic                                 mem_clk,
    output logic                                 rise
);
    import nor_sync_pkg::*;

    logic [DIV_W-1:0] ph_reg, ph_next;
    logic             act_reg, act_next;
    logic             clk_reg, clk_next;
    logic             rise_reg, rise_next;
    logic             gate_neg_reg;
    logic [DIV_W:0]   half;

    // R21 divide by div plus one
    always_comb begin
        half      = (DIV_W+1)'(div) + (DIV_W+1)'(2);
        half      = half >> 1;
        ph_next   = '0;
        act_next  = run;
        clk_next  = 1'b0;
        rise_next = 1'b0;
        if (run && act_reg) begin
            ph_next = (ph_reg == div) ? '0 : ph_reg + 1'b1;
        end
        if (run) begin
            clk_next  = ((DIV_W+1)'(ph_next) < half);
            rise_next = (ph_next == '0);
        end
    end

    // Phase and clock flops.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ph_reg   <= '0;
            act_reg  <= 1'b0;
            clk_reg  <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            ph_reg   <= ph_next;
            act_reg  <= act_next;
            clk_reg  <= clk_next;
            rise_reg <= rise_next;
        end
    end

    // Gate loads the coming cycle's run on the low phase, so the first
    // high phase lines up with the flop-made ratios and cannot glitch.
    always_ff @(negedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gate_neg_reg <= 1'b0;
        end else begin
            gate_neg_reg <= act_next;
        end
    end

    // Ratio one cannot come from a flop, so the gated clock is passed out.
    assign mem_clk = (div == '0) ? (mclk & gate_neg_reg) : clk_reg;
    assign rise    = rise_reg;

endmodule : out_clock_gen

// File: test/nor_flash_model.sv
// Pin-level burst NOR flash model; it latches write words.
// Assumes active-low strobes and data valid at output clock rises.
`timescale 1ns/1ps
module nor_flash_model (
    // Memory pins
    input  wire logic                             mem_clk,
    input  wire logic                             sel_n,
    input  wire logic                             mem_we_n,
    input  wire logic [nor_sync_pkg::DATA_W-1:0]  mem_wdata,
    // Observation
    output logic [nor_sync_pkg::DATA_W-1:0]       last_word,
    output int                                    words
);
    import nor_sync_pkg::*;
    // Words are taken only inside a selected write.
    initial begin
        last_word = '0;
        words = 0;
    end
    always @(posedge mem_clk) begin
        if (!sel_n && !mem_we_n) begin
            last_word <= mem_wdata;
            words <= words + 1;
        end
    end
endmodule : nor_flash_model

// File: test/nor_sync_strobe_chk.sv
// Port-level checker for the strobe timing generator.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module nor_sync_strobe_chk #(
    parameter int NCS = nor_sync_pkg::NUM_CS
) (
    // Clock, reset and request
    input logic                               mclk,
    input logic                               rst_n,
    input logic                               req_start,
    input logic [nor_sync_pkg::CS_W-1:0]      req_select,
    input logic [nor_sync_pkg::DATA_W-1:0]    wr_data,
    input logic [NCS*nor_sync_pkg::DIV_W-1:0] out_clock_divider,
    // Design outputs
    input logic                               busy,
    input logic                               done,
    input logic                               wr_data_take,
    input logic                               rd_sample,
    input logic                               mem_clk,
    input logic [NCS-1:0]                     mem_cs_n,
    input logic                               mem_adv_n,
    input logic                               mem_oe_n,
    input logic                               mem_we_n,
    input logic [nor_sync_pkg::BEN_W-1:0]     mem_ben_n,
    input logic [nor_sync_pkg::DATA_W-1:0]    mem_wdata
);
    import nor_sync_pkg::*;
    logic [CS_W-1:0]  sel_reg, sel_next;
    logic [DIV_W-1:0] dq;
    // Remember the accepted select; the divider lane follows it.
    always_comb begin
        sel_next = sel_reg;
        if (req_start && !busy && !done) sel_next = req_select;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) sel_reg <= '0;
        else sel_reg <= sel_next;
    end
    assign dq = out_clock_divider[DIV_W*sel_reg +: DIV_W];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        req_start && !busy && !done;
    endsequence
    // Two quiet cycles let any half-cycle strobe copy settle first.
    sequence s_quiet;
        !busy && !done ##1 !busy && !done;
    endsequence
    a_take_starts_busy: assert property (s_take |=>
        busy && mem_ben_n == 2'h0)
        else $error("no byte enables at start");
    a_done_one_pulse: assert property (done |-> !busy ##1 !done)
        else $error("done not one pulse");
    a_done_follows_end: assert property ($fell(busy) |-> ##[0:1] done)
        else $error("done missing");
    a_idle_pins_high: assert property (s_quiet |-> &mem_cs_n && mem_adv_n
        && mem_oe_n && mem_we_n && &mem_ben_n && !mem_clk)
        else $error("pins active while idle");
    a_select_matches: assert property (!(&mem_cs_n) |->
        mem_cs_n == ~(NCS'(1) << sel_reg))
        else $error("wrong select");
    a_strobe_exclusive: assert property (!mem_oe_n |-> mem_we_n)
        else $error("both strobes low");
    a_take_loads_data: assert property (wr_data_take |->
        mem_wdata == $past(wr_data))
        else $error("take without load");
    a_data_holds_still: assert property (!wr_data_take |->
        $stable(mem_wdata))
        else $error("data moved without take");
    a_sample_in_read: assert property (rd_sample |-> busy && mem_we_n)
        else $error("stray read sample");
    a_clk_div_two: assert property ($rose(mem_clk) && busy && dq == 2'h1
        |=> !mem_clk)
        else $error("clock high too long");
    a_clk_div_slow: assert property ($rose(mem_clk) && busy && dq[1]
        |=> mem_clk ##1 !mem_clk)
        else $error("clock high time wrong");
endmodule : nor_sync_strobe_chk
bind nor_sync_strobe nor_sync_strobe_chk #(.NCS(NCS))
    nor_sync_strobe_chk_inst (.*);

// File: test/testbench.sv
// Table-driven bench for the strobe timing generator.
// Assumes the package constants and a 125 MHz clock.
`timescale 1ns/1ps
module testbench;
    import nor_sync_pkg::*;
    logic                    mclk, rst_n, req_start, busy, done, take, smp;
    logic                    mem_clk, adv_n, oe_n, we_n;
    logic [DATA_W-1:0]       wr_data, wdata;
    logic [NUM_CS*DIV_W-1:0] odiv;
    logic [NUM_CS-1:0]       cs_n;
    logic [BEN_W-1:0]        ben_n;
    int                      num_errors, cmp_count, r[16];
    // Fields: wr, beats-1, sel, scale, div, half, cs on/off, latch on/off,
    // strobe on/off, cycle, access, burst, clock start.
    int rows[4][16] = '{'{0, 0, 0, 0, 0, 0, 1, 6, 1, 3, 3, 6, 7, 4, 1, 1},
                        '{0, 3, 3, 1, 1, 1, 2, 8, 1, 4, 4, 8, 9, 5, 2, 1},
                        '{1, 1, 5, 0, 2, 0, 2, 9, 2, 5, 3, 8, 10, 4, 3, 1},
                        '{1, 0, 7, 0, 3, 1, 3, 10, 1, 6, 4, 10, 12, 6, 1, 2}};
    // Unused read or write select, latch and cycle fields sit one below, so a wrong pick shows.
    nor_sync_strobe nor_sync_strobe_inst (
        .mclk(mclk), .rst_n(rst_n), .req_start(req_start),
        .req_write(r[0][0]), .req_extra_beats(4'(r[1])),
        .req_select(3'(r[2])), .wr_data(wr_data),
        .select_on_tick(5'(r[6])), .select_read_off_tick(5'(r[7] - r[0])),
        .select_write_off_tick(5'(r[7] - 1 + r[0])),
        .latch_on_tick(5'(r[8])), .latch_read_off_tick(5'(r[9] - r[0])),
        .latch_write_off_tick(5'(r[9] - 1 + r[0])),
        .read_strobe_on_tick(5'(r[10])), .read_strobe_off_tick(5'(r[11])),
        .write_strobe_on_tick(5'(r[10])), .write_strobe_off_tick(5'(r[11])),
        .read_cycle_ticks(5'(r[12] - r[0])),
        .write_cycle_ticks(5'(r[12] - 1 + r[0])),
        .access_ticks(5'(r[13])), .burst_access_ticks(5'(r[14])),
        .clock_start_tick(5'(r[15])), .tick_scale(2'(r[3])),
        .select_half_delay(r[5][0]), .latch_half_delay(r[5][0]),
        .read_strobe_half_delay(r[5][0]), .write_strobe_half_delay(r[5][0]),
        .out_clock_divider(odiv), .busy(busy), .done(done),
        .wr_data_take(take), .rd_sample(smp), .mem_clk(mem_clk),
        .mem_cs_n(cs_n), .mem_adv_n(adv_n), .mem_oe_n(oe_n),
        .mem_we_n(we_n), .mem_ben_n(ben_n), .mem_wdata(wdata));
    nor_flash_model nor_flash_model_inst (
        .mem_clk(mem_clk), .sel_n(&cs_n), .mem_we_n(we_n),
        .mem_wdata(wdata), .last_word(), .words());
    // Functional clock, 8 ns period.
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input string nm, input int exp, input int got);
        cmp_count++;
        if (exp != got) begin
            $display("Error %s expected %0d seen %0d", nm, exp, got);
            num_errors++;
        end
    endtask : chk
    // Cycles to the next divided clock edge.
    function automatic int rs(input int t);
        return (t + 96 - r[15]) % (r[4] + 1);
    endfunction : rs
    function automatic logic idle();
        return &cs_n & adv_n & oe_n & we_n & &ben_n & !busy & !done
            & !mem_clk & (wdata == 16'h0);
    endfunction : idle
    // One access, sampled 1 ns after each rising edge; hold keeps the request up.
    task automatic run(input int i, input bit hold);
        int fst[5], lst[5], nb, ns, bad, f, bx, h;
        logic [4:0] lo;
        @(negedge mclk);
        r = rows[i];
        odiv = {NUM_CS{~2'(r[4])}};
        odiv[DIV_W*r[2] +: DIV_W] = 2'(r[4]);
        req_start = 1'b1;
        fst = '{default: -1};
        lst = '{default: -1};
        nb = 0;
        ns = 0;
        bad = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge mclk);
            #1;
            lo = {mem_clk, ben_n == 2'h0, (r[0] ? we_n : oe_n) == 1'b0,
                  adv_n == 1'b0, cs_n[r[2]] == 1'b0};
            for (int j = 0; j < 5; j++) begin
                if (lo[j] === 1'b1) begin
                    if (fst[j] < 0) fst[j] = k;
                    lst[j] = k + 1;
                end
            end
            nb += int'(busy === 1'b1);
            ns += int'(smp === 1'b1);
            bad += int'((cs_n | (NUM_CS'(1) << r[2])) !== '1);
            bad += int'((r[0] ? oe_n : we_n) !== 1'b1);
            @(negedge mclk);
            if (take === 1'b1) wr_data = wr_data + 16'h1111;
            if (!hold || busy !== 1'b1) req_start = 1'b0;
        end
        f = r[3] + 1;
        bx = r[1] * r[14] * f;
        h = r[5];
        chk("cs_first", r[6]*f + rs(r[6]) + h, fst[0]);
        chk("cs_end", r[7]*f + bx + rs(r[6]) + h, lst[0]);
        chk("adv_first", r[8]*f + rs(r[8]) + h, fst[1]);
        chk("adv_end", r[9]*f + rs(r[9]) + h, lst[1]);
        chk("strobe_first", r[10]*f + rs(r[10]) + h, fst[2]);
        chk("strobe_end", r[11]*f + bx + rs(r[11]) + h, lst[2]);
        chk("ben_first", 0, fst[3]);
        chk("ben_end", r[12]*f + bx, lst[3]);
        chk("busy_len", r[12]*f + bx, nb);
        chk("clk_start", r[15], fst[4]);
        chk("samples", r[0] ? 0 : r[1] + 1, ns);
        chk("stray", 0, bad);
        $display("test %0d done", i);
    endtask : run
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    // Table first, then a held request and a reset in mid-access.
    initial begin
        rst_n = 1'b0;
        req_start = 1'b0;
        wr_data = 16'hA5C3;
        odiv = '0;
        num_errors = 0;
        cmp_count = 0;
        repeat (8) @(negedge mclk);
        chk("reset_idle", 1, int'(idle() === 1'b1));
        rst_n = 1'b1;
        $display("test reset done");
        foreach (rows[i]) run(i, 1'b0);
        run(2, 1'b1);
        @(negedge mclk);
        r = rows[1];
        req_start = 1'b1;
        @(negedge mclk);
        req_start = 1'b0;
        repeat (6) @(negedge mclk);
        rst_n = 1'b0;
        #1;
        chk("abort_idle", 1, int'(idle() === 1'b1));
        @(negedge mclk);
        rst_n = 1'b1;
        $display("test abort done");
        run(3, 1'b0);
        summarize();
    end
endmodule : testbench
